// [ccs_clk_switch.sv]
// Glitch-free source switch and divider for the CPU clock tick.
`timescale 1ns/1ns
module ccs_clk_switch (
    input wire logic clock,
    input wire logic arst_n,
    ccs_sw_if.sw sw
);
    ccs_pkg::ccs_sw_e state;
    logic [4:0] cnt;
    logic [2:0] div;
    logic act_tick;
    logic new_tick;
    logic period_end;

    function automatic logic [4:0] div_top(input logic [2:0] d);
        logic [2:0] c;
        c = (d > ccs_pkg::CCS_MDIV_MAX) ? ccs_pkg::CCS_MDIV_MAX : d;
        div_top = 5'((6'h01 << c) - 6'h01);
    endfunction

    always_comb begin
        act_tick = sw.src_tick[sw.act_src];
        new_tick = sw.src_tick[sw.req_src];
        period_end = act_tick && (cnt == div_top(div));
    end

    // A change only takes effect once the running period has ended; a source
    // change also waits for an edge of the new source, so no short period ever leaves.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= ccs_pkg::CCS_SW_RUN;
            sw.act_src <= ccs_pkg::CCS_SRC_IH;
            div <= ccs_pkg::CCS_CKC_RESET[ccs_pkg::CCS_CKC_MDIV_HI:0];
            cnt <= 5'h00;
        end else begin
            if (act_tick) begin
                cnt <= period_end ? 5'h00 : cnt + 5'h01;
            end
            case (state)
                ccs_pkg::CCS_SW_RUN: begin
                    if (sw.req_src != sw.act_src || sw.req_div != div) begin
                        state <= ccs_pkg::CCS_SW_DRAIN;
                    end
                end
                ccs_pkg::CCS_SW_DRAIN: begin
                    if (period_end && sw.req_src == sw.act_src) begin
                        div <= sw.req_div;
                        state <= ccs_pkg::CCS_SW_RUN;
                    end else if (period_end) begin
                        state <= ccs_pkg::CCS_SW_ARM;
                    end
                end
                ccs_pkg::CCS_SW_ARM: begin
                    if (new_tick) begin
                        sw.act_src <= sw.req_src;
                        div <= sw.req_div;
                        cnt <= 5'h00;
                        state <= ccs_pkg::CCS_SW_RUN;
                    end
                end
                default: begin
                    state <= ccs_pkg::CCS_SW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sw.out_tick <= 1'b0;
        end else begin
            sw.out_tick <= period_end && !sw.hold;
        end
    end
endmodule

// [ccs_pkg.sv]
// Constants and types shared by the CPU clock source selector.
package ccs_pkg;
    // Register select codes on the register port.
    localparam logic [1:0] CCS_SEL_MODE = 2'h0;
    localparam logic [1:0] CCS_SEL_RUN = 2'h1;
    localparam logic [1:0] CCS_SEL_SYS = 2'h2;
    // clock_mode_control fields.
    localparam int CCS_CMC_EXT_MAIN = 7;
    localparam int CCS_CMC_MAIN_PIN = 6;
    localparam int CCS_CMC_SUB_PIN = 4;
    localparam int CCS_CMC_SUB_AMP_B1 = 2;
    localparam int CCS_CMC_SUB_AMP_B0 = 1;
    localparam int CCS_CMC_MAIN_AMP = 0;
    localparam logic [7:0] CCS_CMC_ZERO_MASK = 8'h28;
    localparam logic [7:0] CCS_CMC_RESET = 8'h00;
    // clock_run_control fields.
    localparam int CCS_CSC_X1_STOP = 7;
    localparam int CCS_CSC_SUB_STOP = 6;
    localparam int CCS_CSC_HS_SETTLED = 1;
    localparam int CCS_CSC_HS_STOP = 0;
    localparam logic [7:0] CCS_CSC_RESET = 8'hc0;
    // system_clock_control fields.
    localparam int CCS_CKC_CLS = 7;
    localparam int CCS_CKC_CSS = 6;
    localparam int CCS_CKC_MCS = 5;
    localparam int CCS_CKC_MCM = 4;
    localparam int CCS_CKC_SUB_DIVIDE = 3;
    localparam int CCS_CKC_MDIV_HI = 2;
    localparam logic [7:0] CCS_CKC_RESET = 8'h09;
    // Option byte fields.
    localparam int CCS_OPT_WD_STBY = 0;
    localparam int CCS_OPT_WD_EN = 4;
    // Timing.
    localparam int CCS_CLK_NS = 10;
    localparam int CCS_HS_SETTLE_NS = 10000;
    localparam int CCS_HS_SETTLE_CYC = (CCS_HS_SETTLE_NS + CCS_CLK_NS - 1)
        / CCS_CLK_NS;
    localparam logic [2:0] CCS_MDIV_MAX = 3'h5;
    typedef enum logic [1:0] {
        CCS_SRC_IH = 2'b00,
        CCS_SRC_MX = 2'b01,
        CCS_SRC_SUB = 2'b10
    } ccs_src_e;
    typedef enum logic [1:0] {
        CCS_SW_RUN = 2'b00,
        CCS_SW_DRAIN = 2'b01,
        CCS_SW_ARM = 2'b11
    } ccs_sw_e;
endpackage

// [ccs_sw_if.sv]
// Signals between the controller and the glitch-free clock switch.
`timescale 1ns/1ns
interface ccs_sw_if;
    logic [2:0] src_tick;
    ccs_pkg::ccs_src_e req_src;
    logic [2:0] req_div;
    logic hold;
    logic out_tick;
    ccs_pkg::ccs_src_e act_src;
    modport ctrl (output src_tick, output req_src, output req_div,
        output hold, input out_tick, input act_src);
    modport sw (input src_tick, input req_src, input req_div,
        input hold, output out_tick, output act_src);
endinterface

// [ccs_tick_sync.sv]
// Oscillator pin synchroniser that yields one tick per rising edge.
`timescale 1ns/1ns
module ccs_tick_sync (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic osc_in,
    output logic tick
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            tick <= 1'b0;
        end else begin
            meta <= osc_in;
            sync <= meta;
            prev <= sync;
            tick <= sync & ~prev;
        end
    end
endmodule

// [ccs_top.sv]
// CPU clock source selector: registers, oscillator control and status.
// What this block does
// - Main select 0 runs CPU from internal oscillator divided 1 to 32.
// - STOP instruction enters STOP mode and halts internal oscillator.
// - Writing internal oscillator stop bit 1 stops the oscillator.
// - Status bits report the source: 00 internal, 01 main, 1x sub.
// - Sub crystal pins are input ports after reset and while unused.
// - The mode control register takes one write only after reset.
// - Clearing the sub oscillator stop bit starts the sub oscillator once its pins are in oscillator mode.
// - Sub select 1 runs CPU from sub clock, halved when divide set.
// - On sub clock peripherals share it; converters not guaranteed.
// - Writing sub oscillator stop bit 1 stops the sub oscillator.
// - STOP mode leaves the sub oscillator running.
// - Low-speed oscillator never drives the CPU, only the watchdog.
// - Low-speed oscillator starts after reset when watchdog enabled.
// - Low-speed oscillator runs always while the watchdog operates.
// - Standby watchdog bit 0 plus HALT or STOP stops low-speed osc.
// - Watchdog enable bit 0 keeps the low-speed oscillator stopped.
// - Clearing the internal oscillator stop bit restarts it.
// - After reset internal oscillator runs and drives the CPU.
`timescale 1ns/1ns
module ccs_top (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [1:0] sfr_sel,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic stop_exec,
    input wire logic halt_exec,
    input wire logic standby_release,
    input wire logic [7:0] option_byte,
    input wire logic ih_osc_clk,
    input wire logic mx_osc_clk,
    input wire logic sub_osc_clk,
    output logic ih_osc_run,
    output logic mx_osc_run,
    output logic sub_osc_run,
    output logic ls_osc_run,
    output logic sub_pins_as_port,
    output logic cpu_tick,
    output logic periph_tick,
    output logic adc_iic_unguaranteed,
    output logic stop_mode,
    output logic halt_mode
);
    localparam int SETTLE_W = $clog2(ccs_pkg::CCS_HS_SETTLE_CYC + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_END =
        SETTLE_W'(ccs_pkg::CCS_HS_SETTLE_CYC);

    logic [7:0] clock_mode_control;
    logic mode_locked;
    logic x1_stop;
    logic sub_osc_stop;
    logic internal_hs_osc_stop;
    logic sub_clock_select;
    logic main_clock_select;
    logic sub_divide;
    logic [2:0] main_divide_ratio;
    logic hs_settled;
    logic [SETTLE_W-1:0] settle_cnt;
    logic opt_loaded;
    logic watchdog_enable_opt;
    logic watchdog_standby_run;
    logic cpu_on_sub_status;
    logic main_source_status;
    logic wr_mode;
    logic wr_run;
    logic wr_sys;
    logic [7:0] next_rdata;

    ccs_sw_if swif ();

    // ------------------------------------------------------------------
    // Oscillator pin synchronisers and the clock switch
    // ------------------------------------------------------------------

    ccs_tick_sync ih_sync (
        .clock(clock),
        .arst_n(arst_n),
        .osc_in(ih_osc_clk),
        .tick(swif.src_tick[ccs_pkg::CCS_SRC_IH])
    );

    ccs_tick_sync mx_sync (
        .clock(clock),
        .arst_n(arst_n),
        .osc_in(mx_osc_clk),
        .tick(swif.src_tick[ccs_pkg::CCS_SRC_MX])
    );

    ccs_tick_sync sub_sync (
        .clock(clock),
        .arst_n(arst_n),
        .osc_in(sub_osc_clk),
        .tick(swif.src_tick[ccs_pkg::CCS_SRC_SUB])
    );

    ccs_clk_switch clk_switch (
        .clock(clock),
        .arst_n(arst_n),
        .sw(swif.sw)
    );

    // The low-speed oscillator has no path into this selection.
    always_comb begin
        if (sub_clock_select) begin
            swif.req_src = ccs_pkg::CCS_SRC_SUB;
            swif.req_div = {2'b00, sub_divide};
        end else if (main_clock_select) begin
            swif.req_src = ccs_pkg::CCS_SRC_MX;
            swif.req_div = main_divide_ratio;
        end else begin
            swif.req_src = ccs_pkg::CCS_SRC_IH;
            swif.req_div = main_divide_ratio;
        end
        swif.hold = stop_mode || stop_exec;
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------

    always_comb begin
        wr_mode = sfr_wr && sfr_sel == ccs_pkg::CCS_SEL_MODE;
        wr_run = sfr_wr && sfr_sel == ccs_pkg::CCS_SEL_RUN;
        wr_sys = sfr_wr && sfr_sel == ccs_pkg::CCS_SEL_SYS;
    end

    // Only the first write after reset lands; later writes are dropped.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clock_mode_control <= ccs_pkg::CCS_CMC_RESET;
            mode_locked <= 1'b0;
        end else if (wr_mode && !mode_locked) begin
            clock_mode_control <= sfr_wdata & ~ccs_pkg::CCS_CMC_ZERO_MASK;
            mode_locked <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            x1_stop <= ccs_pkg::CCS_CSC_RESET[ccs_pkg::CCS_CSC_X1_STOP];
            sub_osc_stop <= ccs_pkg::CCS_CSC_RESET[ccs_pkg::CCS_CSC_SUB_STOP];
            internal_hs_osc_stop <=
                ccs_pkg::CCS_CSC_RESET[ccs_pkg::CCS_CSC_HS_STOP];
        end else if (wr_run) begin
            x1_stop <= sfr_wdata[ccs_pkg::CCS_CSC_X1_STOP];
            sub_osc_stop <= sfr_wdata[ccs_pkg::CCS_CSC_SUB_STOP];
            internal_hs_osc_stop <=
                sfr_wdata[ccs_pkg::CCS_CSC_HS_STOP];
        end
    end

    // The two status bits of this register are read-only.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sub_clock_select <= ccs_pkg::CCS_CKC_RESET[ccs_pkg::CCS_CKC_CSS];
            main_clock_select <=
                ccs_pkg::CCS_CKC_RESET[ccs_pkg::CCS_CKC_MCM];
            sub_divide <= ccs_pkg::CCS_CKC_RESET[ccs_pkg::CCS_CKC_SUB_DIVIDE];
            main_divide_ratio <=
                ccs_pkg::CCS_CKC_RESET[ccs_pkg::CCS_CKC_MDIV_HI:0];
        end else if (wr_sys) begin
            sub_clock_select <= sfr_wdata[ccs_pkg::CCS_CKC_CSS];
            main_clock_select <= sfr_wdata[ccs_pkg::CCS_CKC_MCM];
            sub_divide <= sfr_wdata[ccs_pkg::CCS_CKC_SUB_DIVIDE];
            main_divide_ratio <= sfr_wdata[ccs_pkg::CCS_CKC_MDIV_HI:0];
        end
    end

    // ------------------------------------------------------------------
    // Standby modes
    // ------------------------------------------------------------------

    // An instruction in the same cycle as a release still enters standby.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stop_mode <= 1'b0;
        end else if (stop_exec) begin
            stop_mode <= 1'b1;
        end else if (standby_release) begin
            stop_mode <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            halt_mode <= 1'b0;
        end else if (halt_exec) begin
            halt_mode <= 1'b1;
        end else if (standby_release) begin
            halt_mode <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Option byte capture
    // ------------------------------------------------------------------

    // The option byte is taken once, in the first cycle after release.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            opt_loaded <= 1'b0;
            watchdog_enable_opt <= 1'b0;
            watchdog_standby_run <= 1'b0;
        end else if (!opt_loaded) begin
            opt_loaded <= 1'b1;
            watchdog_enable_opt <= option_byte[ccs_pkg::CCS_OPT_WD_EN];
            watchdog_standby_run <= option_byte[ccs_pkg::CCS_OPT_WD_STBY];
        end
    end

    // ------------------------------------------------------------------
    // Oscillator run controls
    // ------------------------------------------------------------------

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ih_osc_run <= 1'b0;
            mx_osc_run <= 1'b0;
            sub_osc_run <= 1'b0;
        end else begin
            ih_osc_run <= !internal_hs_osc_stop && !stop_mode;
            mx_osc_run <= !x1_stop && !stop_mode &&
                clock_mode_control[ccs_pkg::CCS_CMC_MAIN_PIN];
            sub_osc_run <= !sub_osc_stop &&
                clock_mode_control[ccs_pkg::CCS_CMC_SUB_PIN];
        end
    end

    // Software has no control here: only the option byte and standby do.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ls_osc_run <= 1'b0;
        end else begin
            ls_osc_run <= opt_loaded && watchdog_enable_opt &&
                !((stop_mode || halt_mode) && !watchdog_standby_run);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sub_pins_as_port <= 1'b1;
        end else begin
            sub_pins_as_port <=
                !clock_mode_control[ccs_pkg::CCS_CMC_SUB_PIN];
        end
    end

    // Counts the settling time after each internal oscillator start.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            settle_cnt <= '0;
            hs_settled <= 1'b0;
        end else if (!ih_osc_run) begin
            settle_cnt <= '0;
            hs_settled <= 1'b0;
        end else if (settle_cnt != SETTLE_END) begin
            settle_cnt <= settle_cnt + 1'b1;
        end else begin
            hs_settled <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Clock outputs and source status
    // ------------------------------------------------------------------

    always_comb begin
        cpu_on_sub_status = swif.act_src == ccs_pkg::CCS_SRC_SUB;
        main_source_status = swif.act_src == ccs_pkg::CCS_SRC_MX;
    end

    // HALT stops only the CPU tick; the peripherals keep their clock.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cpu_tick <= 1'b0;
            periph_tick <= 1'b0;
            adc_iic_unguaranteed <= 1'b0;
        end else begin
            cpu_tick <= swif.out_tick && !halt_mode && !stop_exec;
            periph_tick <= swif.out_tick && !stop_exec;
            adc_iic_unguaranteed <= cpu_on_sub_status;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------

    always_comb begin
        next_rdata = 8'h00;
        case (sfr_sel)
            ccs_pkg::CCS_SEL_MODE: begin
                next_rdata = clock_mode_control;
            end
            ccs_pkg::CCS_SEL_RUN: begin
                next_rdata[ccs_pkg::CCS_CSC_X1_STOP] = x1_stop;
                next_rdata[ccs_pkg::CCS_CSC_SUB_STOP] = sub_osc_stop;
                next_rdata[ccs_pkg::CCS_CSC_HS_SETTLED] = hs_settled;
                next_rdata[ccs_pkg::CCS_CSC_HS_STOP] = internal_hs_osc_stop;
            end
            ccs_pkg::CCS_SEL_SYS: begin
                next_rdata[ccs_pkg::CCS_CKC_CLS] = cpu_on_sub_status;
                next_rdata[ccs_pkg::CCS_CKC_CSS] = sub_clock_select;
                next_rdata[ccs_pkg::CCS_CKC_MCS] = main_source_status;
                next_rdata[ccs_pkg::CCS_CKC_MCM] = main_clock_select;
                next_rdata[ccs_pkg::CCS_CKC_SUB_DIVIDE] = sub_divide;
                next_rdata[ccs_pkg::CCS_CKC_MDIV_HI:0] = main_divide_ratio;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end
endmodule

// [ccs_top_checker.sv]
// Concurrent checks on the ports of the CPU clock source selector.
`timescale 1ns/1ns
module ccs_top_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [1:0] sfr_sel,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic stop_exec,
    input wire logic halt_exec,
    input wire logic [7:0] option_byte,
    input wire logic ih_osc_run,
    input wire logic sub_osc_run,
    input wire logic ls_osc_run,
    input wire logic sub_pins_as_port,
    input wire logic cpu_tick,
    input wire logic periph_tick,
    input wire logic adc_iic_unguaranteed,
    input wire logic stop_mode,
    input wire logic halt_mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    logic run_wr;
    assign run_wr = sfr_wr && (sfr_sel == ccs_pkg::CCS_SEL_RUN);
    property p_hs_stop;
        run_wr && sfr_wdata[0] |=> ##1 !ih_osc_run;
    endproperty
    a_hs_stop: assert property (p_hs_stop) else $error("hs on");
    property p_hs_restart;
        run_wr && !sfr_wdata[0] && !stop_mode && !stop_exec
            |=> ##1 ih_osc_run;
    endproperty
    a_hs_restart: assert property (p_hs_restart) else $error("hs off");
    property p_sub_start;
        run_wr && !sfr_wdata[6] && !sub_pins_as_port |=> ##1 sub_osc_run;
    endproperty
    a_sub_start: assert property (p_sub_start) else $error("sub not on");
    property p_sub_stop;
        run_wr && sfr_wdata[6] |=> ##1 !sub_osc_run;
    endproperty
    a_sub_stop: assert property (p_sub_stop) else $error("sub still on");
    property p_pins;
        sub_osc_run |-> !sub_pins_as_port;
    endproperty
    a_pins: assert property (p_pins) else $error("pins port");
    property p_stop;
        stop_exec |=> stop_mode ##1 !ih_osc_run;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_stop_ticks;
        stop_mode |-> !cpu_tick && !periph_tick;
    endproperty
    a_stop_ticks: assert property (p_stop_ticks) else $error("tick");
    property p_sub_keep;
        stop_exec && sub_osc_run |=> sub_osc_run [*2];
    endproperty
    a_sub_keep: assert property (p_sub_keep) else $error("sub off");
    property p_ih_start;
        $rose(arst_n) |-> ##[1:3] ih_osc_run;
    endproperty
    a_ih_start: assert property (p_ih_start) else $error("hs no start");
    property p_ls_start;
        $rose(arst_n) && option_byte[4] |-> ##[1:3] ls_osc_run;
    endproperty
    a_ls_start: assert property (p_ls_start) else $error("ls no start");
    property p_ls_off;
        !option_byte[4] |-> !ls_osc_run;
    endproperty
    a_ls_off: assert property (p_ls_off) else $error("ls runs");
    property p_ls_keep;
        $past(ls_osc_run) && option_byte[4] && option_byte[0] |-> ls_osc_run;
    endproperty
    a_ls_keep: assert property (p_ls_keep) else $error("ls halted");
    property p_ls_halt;
        (halt_exec || stop_exec) && !option_byte[0] |=> ##1 !ls_osc_run;
    endproperty
    a_ls_halt: assert property (p_ls_halt) else $error("ls on");
    c_stop: cover property (stop_exec ##1 stop_mode);
    c_halt: cover property (halt_exec ##1 halt_mode);
    c_sub: cover property ($rose(adc_iic_unguaranteed));
endmodule

// [test_ccs_top.sv]
// Self-checking bench for the CPU clock source selector.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module test_ccs_top;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] sfr_sel = 2'h0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic stop_exec = 1'b0;
    logic halt_exec = 1'b0;
    logic standby_release = 1'b0;
    logic [7:0] option_byte = 8'h11;
    logic ih_osc_clk = 1'b0;
    logic mx_osc_clk = 1'b0;
    logic sub_osc_clk = 1'b0;
    logic ih_osc_run, mx_osc_run, sub_osc_run, ls_osc_run, sub_pins_as_port;
    logic cpu_tick, periph_tick, adc_iic_unguaranteed, stop_mode, halt_mode;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int nc;
    int np;
    ccs_top DUT (.clock(clock), .arst_n(arst_n), .sfr_sel(sfr_sel),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .stop_exec(stop_exec),
        .halt_exec(halt_exec), .standby_release(standby_release),
        .option_byte(option_byte), .ih_osc_clk(ih_osc_clk),
        .mx_osc_clk(mx_osc_clk), .sub_osc_clk(sub_osc_clk),
        .ih_osc_run(ih_osc_run), .mx_osc_run(mx_osc_run),
        .sub_osc_run(sub_osc_run), .ls_osc_run(ls_osc_run),
        .sub_pins_as_port(sub_pins_as_port), .cpu_tick(cpu_tick),
        .periph_tick(periph_tick),
        .adc_iic_unguaranteed(adc_iic_unguaranteed),
        .stop_mode(stop_mode), .halt_mode(halt_mode));
    initial begin
        forever #5 clock = ~clock;
    end
    // Oscillators hold still while their enables are low.
    always #20 if (ih_osc_run === 1'b1) ih_osc_clk = ~ih_osc_clk;
    always #30 if (mx_osc_run === 1'b1) mx_osc_clk = ~mx_osc_clk;
    always #50 if (sub_osc_run === 1'b1) sub_osc_clk = ~sub_osc_clk;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clock);
        sfr_sel = sel;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clock);
        sfr_sel = sel;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp,
        input string nm);
        logic [7:0] v;
        rd(sel, v);
        `CHK(nm, exp, v)
    endtask
    task automatic poll_ckc(input logic [7:0] exp, input string nm);
        logic [7:0] v;
        int n;
        n = 0;
        do begin
            rd(ccs_pkg::CCS_SEL_SYS, v);
            n++;
        end while (v !== exp && n < 100);
        `CHK(nm, exp, v)
    endtask
    task automatic pulse(input int k);
        @(negedge clock);
        if (k == 0) stop_exec = 1'b1;
        else if (k == 1) halt_exec = 1'b1;
        else standby_release = 1'b1;
        @(negedge clock);
        stop_exec = 1'b0;
        halt_exec = 1'b0;
        standby_release = 1'b0;
    endtask
    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (cpu_tick !== 1'b1 && n < 2000);
    endtask
    // The first intervals after a change are discarded.
    task automatic chk_period(input int exp, input string nm);
        int n;
        repeat (3) next_tick(n);
        `CHK(nm, exp, n)
    endtask
    task automatic do_reset(input logic [7:0] opt);
        @(negedge clock);
        arst_n = 1'b0;
        option_byte = opt;
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        `CHK("ls_run", opt[4], ls_osc_run)
        `CHK("ih_run", 1'b1, ih_osc_run)
        `CHK("pins", 1'b1, sub_pins_as_port)
    endtask
    initial begin
        do_reset(8'h11);
        rd_chk(ccs_pkg::CCS_SEL_MODE, 8'h00, "cmc_rst");
        rd_chk(ccs_pkg::CCS_SEL_RUN, 8'hc0, "csc_rst");
        rd_chk(ccs_pkg::CCS_SEL_SYS, 8'h09, "ckc_rst");
        rd_chk(2'h3, 8'h00, "unmapped");
        chk_period(8, "rst_div");
        end_test("reset");
        for (int d = 0; d < 6; d++) begin
            wr(ccs_pkg::CCS_SEL_SYS, 8'h08 | 8'(d));
            chk_period(4 << d, "div");
        end
        wr(ccs_pkg::CCS_SEL_SYS, 8'h06);
        chk_period(128, "div6");
        end_test("divide");
        wr(ccs_pkg::CCS_SEL_MODE, 8'h56);
        wr(ccs_pkg::CCS_SEL_MODE, 8'h00);
        rd_chk(ccs_pkg::CCS_SEL_MODE, 8'h56, "cmc_once");
        wr(ccs_pkg::CCS_SEL_RUN, 8'h00);
        repeat (2) @(negedge clock);
        `CHK("sub_run", 1'b1, sub_osc_run)
        `CHK("pins_used", 1'b0, sub_pins_as_port)
        `CHK("mx_run", 1'b1, mx_osc_run)
        end_test("mode");
        wr(ccs_pkg::CCS_SEL_SYS, 8'h40);
        poll_ckc(8'hc0, "ckc_sub");
        chk_period(10, "sub_div1");
        `CHK("unguar", 1'b1, adc_iic_unguaranteed)
        wr(ccs_pkg::CCS_SEL_SYS, 8'h48);
        chk_period(20, "sub_div2");
        pulse(0);
        repeat (2) @(negedge clock);
        `CHK("stop_mode", 1'b1, stop_mode)
        `CHK("ih_stop", 1'b0, ih_osc_run)
        `CHK("sub_kept", 1'b1, sub_osc_run)
        pulse(2);
        end_test("sub");
        wr(ccs_pkg::CCS_SEL_SYS, 8'h10);
        poll_ckc(8'h30, "ckc_main");
        chk_period(6, "main");
        `CHK("guar", 1'b0, adc_iic_unguaranteed)
        wr(ccs_pkg::CCS_SEL_RUN, 8'h01);
        repeat (2) @(negedge clock);
        `CHK("ih_off", 1'b0, ih_osc_run)
        wr(ccs_pkg::CCS_SEL_RUN, 8'h00);
        repeat (2) @(negedge clock);
        `CHK("ih_on", 1'b1, ih_osc_run)
        repeat (ccs_pkg::CCS_HS_SETTLE_CYC) @(negedge clock);
        wr(ccs_pkg::CCS_SEL_RUN, 8'h40);
        repeat (2) @(negedge clock);
        `CHK("sub_off", 1'b0, sub_osc_run)
        wr(ccs_pkg::CCS_SEL_SYS, 8'h01);
        poll_ckc(8'h01, "ckc_ih");
        chk_period(8, "ih_div2");
        end_test("switch");
        pulse(1);
        nc = 0;
        np = 0;
        repeat (40) begin
            @(negedge clock);
            if (cpu_tick === 1'b1) nc++;
            if (periph_tick === 1'b1) np++;
        end
        `CHK("halt_mode", 1'b1, halt_mode)
        `CHK("halt_cpu", 0, nc)
        `CHK("halt_per", 1'b1, np > 0)
        `CHK("ls_halt_on", 1'b1, ls_osc_run)
        pulse(2);
        do_reset(8'h10);
        pulse(1);
        repeat (2) @(negedge clock);
        `CHK("ls_halt_off", 1'b0, ls_osc_run)
        pulse(2);
        do_reset(8'h00);
        end_test("watchdog");
        close_out();
    end
endmodule
bind ccs_top ccs_top_checker u_chk (.clock(clock), .arst_n(arst_n),
    .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .stop_exec(stop_exec), .halt_exec(halt_exec),
    .option_byte(option_byte), .ih_osc_run(ih_osc_run),
    .sub_osc_run(sub_osc_run), .ls_osc_run(ls_osc_run),
    .sub_pins_as_port(sub_pins_as_port), .cpu_tick(cpu_tick),
    .periph_tick(periph_tick), .adc_iic_unguaranteed(adc_iic_unguaranteed),
    .stop_mode(stop_mode), .halt_mode(halt_mode));
